//--- core/nvmseq_params.svh
// Register offsets, field positions, reset values and timing counts for the NVM access block
`ifndef NVMSEQ_PARAMS_SVH
`define NVMSEQ_PARAMS_SVH
`define NVM_OFS_TEST_UNLOCK 8'h91
`define NVM_OFS_PUMP_BIAS 8'hA2
`define NVM_OFS_WORD_DATA 8'hA3
`define NVM_OFS_PROG_DAC 8'hF3
`define NVM_OFS_ADDR_CTRL 8'hF9
`define NVM_UNLOCK_CODE 6'h3B
`define NVM_WORDS 43
`define NVM_ADDR_RST 6'h3F
`define NVM_PUMP_BIT 7
`define NVM_DAC_PWR_BIT 7
`define NVM_WREN_BIT 6
`define NVM_CLK_MHZ 25
`define NVM_SETTLE_US 10
`define NVM_SETTLE_CYC (`NVM_SETTLE_US * `NVM_CLK_MHZ)
`endif

//--- core/nvmseq_pkg.sv
// Types shared by the NVM access block
package nvmseq_pkg;
    typedef enum logic [1:0] {
        NVMSEQ_IDLE = 2'b00,
        NVMSEQ_PROG = 2'b01,
        NVMSEQ_DONE = 2'b10
    } nvmseq_state_t;
endpackage

//--- core/nvmseq_ecc_dec.sv
// Hamming syndrome decoder for one 7-bit stored word
`timescale 1ns/1ps
`default_nettype none
module nvmseq_ecc_dec (
    // Stored word
    input wire logic [6:0] word_i,
    // Decoded result
    output logic [3:0] data_o,
    output logic single_o,
    output logic double_o
);
    logic [2:0] syn;
    logic [3:0] d;

    // Stored check bits are inverted parity
    always_comb
    begin
        d = word_i[3:0];
        syn[0] = ~(d[2] ^ d[1] ^ d[0]) ^ word_i[4];
        syn[1] = ~(d[3] ^ d[1] ^ d[0]) ^ word_i[5];
        syn[2] = ~(d[3] ^ d[2] ^ d[0]) ^ word_i[6];
        // Distance-3 code: syndromes matching a data column correct it
        data_o = d;
        case (syn)
            3'b011: data_o[1] = ~d[1];
            3'b101: data_o[2] = ~d[2];
            3'b110: data_o[3] = ~d[3];
            3'b111: data_o[0] = ~d[0];
            default: data_o = d;
        endcase
        single_o = (syn != 3'b000);
        // Every syndrome names one bit, so a double flip cannot be told apart
        double_o = 1'b0;
    end
endmodule // nvmseq_ecc_dec
`default_nettype wire

//--- core/nvmseq_top.sv
// NVM word store with check bits, programming sequence registers and read decode
//
// Functional notes
// - Array of 43 words, 7 bits each, reached via special function registers.
// - Bits 6..4 hold check bits, bits 3..0 hold data.
// - Code corrects single flipped bits; two flips are not detected (ecc_double_o stays 0).
// - Data location: writes load word, reads return stored check bits, corrected data and test bit.
`timescale 1ns/1ps
`default_nettype none
`include "nvmseq_params.svh"
module nvmseq_top
    import nvmseq_pkg::*;
#(
    parameter int WORDS = `NVM_WORDS
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Special function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    // Status
    output logic programming_o,
    output logic prog_done_o,
    output logic ecc_single_o,
    output logic ecc_double_o,
    output logic test_out_o,
    output logic [5:0] generator_reference_voltage_o,
    output logic [7:0] radio_detector_threshold_o
);
    logic [6:0] mem_reg [WORDS];
    logic [5:0] test_unlock_vector_reg;
    logic [7:0] pump_bias_control_reg;
    logic [7:0] program_voltage_dac_reg;
    logic [6:0] nvm_address_control_reg;
    logic [7:0] nvm_word_data_reg;
    logic [7:0] rdata_reg;
    logic single_reg;
    logic double_reg;
    logic [3:0] dec_data;
    logic dec_single;
    logic dec_double;
    logic [6:0] fetched;
    logic [5:0] target_word_address;
    logic program_mode_enable;
    logic armed;
    nvmseq_state_t state_reg;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    assign target_word_address = nvm_address_control_reg[5:0];
    assign program_mode_enable = nvm_address_control_reg[`NVM_WREN_BIT];
    // Pulse is live only when all supplies are up and write unlocked
    assign armed = program_mode_enable && pump_bias_control_reg[`NVM_PUMP_BIT]
        && program_voltage_dac_reg[`NVM_DAC_PWR_BIT] && program_voltage_dac_reg[5:0] != 6'h00
        && test_unlock_vector_reg == `NVM_UNLOCK_CODE;
    assign fetched = (int'(target_word_address) < WORDS) ? mem_reg[target_word_address] : 7'h00;

    // Control registers
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            test_unlock_vector_reg <= 6'h00;
            pump_bias_control_reg <= 8'h00;
            program_voltage_dac_reg <= 8'h00;
            nvm_address_control_reg <= {1'b0, `NVM_ADDR_RST};
            nvm_word_data_reg <= 8'h00;
        end
        else if (sfr_wr_i)
        begin
            if (hit(sfr_addr_i, `NVM_OFS_TEST_UNLOCK))
                test_unlock_vector_reg <= sfr_wdata_i[5:0];
            else if (hit(sfr_addr_i, `NVM_OFS_PUMP_BIAS))
                pump_bias_control_reg <= sfr_wdata_i;
            else if (hit(sfr_addr_i, `NVM_OFS_WORD_DATA))
                nvm_word_data_reg <= sfr_wdata_i;
            else if (hit(sfr_addr_i, `NVM_OFS_PROG_DAC))
                program_voltage_dac_reg <= sfr_wdata_i;
            else if (hit(sfr_addr_i, `NVM_OFS_ADDR_CTRL))
                nvm_address_control_reg <= sfr_wdata_i[6:0];
        end
    end

    // Array cell written while programming voltage is applied
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            for (int i = 0; i < WORDS; i++)
                mem_reg[i] <= 7'h00;
        end
        else if (armed && int'(target_word_address) < WORDS)
        begin
            mem_reg[target_word_address] <= nvm_word_data_reg[6:0];
        end
    end

    // Programming phase tracking
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
            state_reg <= NVMSEQ_IDLE;
        else
        begin
            case (state_reg)
                NVMSEQ_IDLE: if (armed) state_reg <= NVMSEQ_PROG;
                NVMSEQ_PROG: if (!armed) state_reg <= NVMSEQ_DONE;
                NVMSEQ_DONE: if (!program_mode_enable) state_reg <= NVMSEQ_IDLE;
                default: state_reg <= NVMSEQ_IDLE;
            endcase
        end
    end

    nvmseq_ecc_dec u_dec (
        .word_i(fetched),
        .data_o(dec_data),
        .single_o(dec_single),
        .double_o(dec_double)
    );

    // Read data and decode status
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            rdata_reg <= 8'h00;
            single_reg <= 1'b0;
            double_reg <= 1'b0;
        end
        else if (sfr_rd_i)
        begin
            rdata_reg <= 8'h00;
            if (hit(sfr_addr_i, `NVM_OFS_WORD_DATA))
            begin
                rdata_reg <= {armed, fetched[6:4], dec_data};
                single_reg <= dec_single;
                double_reg <= dec_double;
            end
        end
    end

    assign sfr_rdata_o = rdata_reg;
    assign programming_o = (state_reg == NVMSEQ_PROG);
    assign prog_done_o = (state_reg == NVMSEQ_DONE);
    assign ecc_single_o = single_reg;
    assign ecc_double_o = double_reg;
    assign test_out_o = rdata_reg[7];
    assign generator_reference_voltage_o = program_voltage_dac_reg[5:0];
    assign radio_detector_threshold_o = nvm_word_data_reg;

    a_prog_writes: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        armed && target_word_address == 6'h02 |=> mem_reg[2] == $past(nvm_word_data_reg[6:0]))
        else $error("word not stored");
    a_wren_gate: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !program_mode_enable |=> $stable(mem_reg[3]))
        else $error("store without write enable");
    a_unlock_gate: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        test_unlock_vector_reg != `NVM_UNLOCK_CODE |=> $stable(mem_reg[2]))
        else $error("store while locked");
    a_pump_gate: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !pump_bias_control_reg[`NVM_PUMP_BIT] |=> !programming_o)
        else $error("store without pump");
    a_read_path: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        sfr_rd_i && sfr_addr_i == `NVM_OFS_WORD_DATA |=> sfr_rdata_o[6:4] == $past(fetched[6:4]))
        else $error("read check bits wrong");
    a_clean_read: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        sfr_rd_i && sfr_addr_i == `NVM_OFS_WORD_DATA && !dec_single |=> !ecc_single_o)
        else $error("false error flag");
    a_prog_phase: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        armed && state_reg == NVMSEQ_IDLE |=> programming_o)
        else $error("phase not entered");
    a_exit_phase: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        prog_done_o && !program_mode_enable |=> !prog_done_o)
        else $error("phase not left");
    c_program: cover property (@(posedge core_clk_i) disable iff (!rstn_i) programming_o);
    c_done: cover property (@(posedge core_clk_i) disable iff (!rstn_i) prog_done_o);
    c_single: cover property (@(posedge core_clk_i) disable iff (!rstn_i) ecc_single_o);
endmodule // nvmseq_top
`default_nettype wire

//--- tb/nvmseq_fw_model.sv
// Firmware model driving the NVM special function registers
`timescale 1ns/1ps
`default_nettype none
`include "nvmseq_params.svh"
module nvmseq_fw_model #(
    parameter int PULSE_CYC = 20
) (
    // Clock
    input wire logic core_clk_i,
    // Register port
    output logic [7:0] sfr_addr_o,
    output logic [7:0] sfr_wdata_o,
    output logic sfr_wr_o,
    output logic sfr_rd_o,
    // Status seen
    input wire logic prog_i,
    input wire logic done_i,
    input wire logic [7:0] rdata_i,
    input wire logic [5:0] dac_i
);
    logic saw_pulse;
    logic saw_done;
    logic [7:0] live_word;
    logic [5:0] live_dac;
    initial
    begin
        sfr_addr_o = 8'h00;
        sfr_wdata_o = 8'h00;
        sfr_wr_o = 1'b0;
        sfr_rd_o = 1'b0;
        saw_pulse = 1'b0;
        saw_done = 1'b0;
        live_word = 8'h00;
        live_dac = 6'h00;
    end
    function automatic logic [6:0] enc(input logic [3:0] d);
        return {~(d[3] ^ d[2] ^ d[0]), ~(d[3] ^ d[1] ^ d[0]), ~(d[2] ^ d[1] ^ d[0]), d};
    endfunction
    // One access; released bus shows inverted values
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge core_clk_i);
        #1;
        sfr_addr_o = a;
        sfr_wdata_o = d;
        sfr_wr_o = w;
        sfr_rd_o = !w;
        @(posedge core_clk_i);
        #1;
        sfr_wr_o = 1'b0;
        sfr_rd_o = 1'b0;
        sfr_addr_o = ~a;
        sfr_wdata_o = ~d;
    endtask
    task automatic settle();
        repeat (`NVM_SETTLE_CYC) @(posedge core_clk_i);
    endtask
    task automatic program_word(input logic [5:0] a, input logic [3:0] d,
                                input logic [6:0] flip, input logic pump);
        logic [6:0] w;
        w = enc(d) ^ flip;
        saw_pulse = 1'b0;
        saw_done = 1'b0;
        live_word = 8'h00;
        live_dac = 6'h00;
        if (a < 6'h02 || a > 6'h0F)
        begin
            return;
        end
        acc(`NVM_OFS_TEST_UNLOCK, 8'h3B, 1'b1);
        acc(`NVM_OFS_PROG_DAC, 8'h00, 1'b1);
        acc(`NVM_OFS_PUMP_BIAS, {pump, 7'h00}, 1'b1);
        acc(`NVM_OFS_ADDR_CTRL, {2'b00, a}, 1'b1);
        acc(`NVM_OFS_WORD_DATA, {1'b0, w}, 1'b1);
        settle();
        acc(`NVM_OFS_ADDR_CTRL, {2'b01, a}, 1'b1);
        acc(`NVM_OFS_PROG_DAC, 8'hC0, 1'b1);
        settle();
        acc(`NVM_OFS_PROG_DAC, 8'hD7, 1'b1);
        repeat (PULSE_CYC)
        begin
            @(posedge core_clk_i);
            #1;
            if (prog_i === 1'b1)
                saw_pulse = 1'b1;
        end
        live_dac = dac_i;
        acc(`NVM_OFS_WORD_DATA, 8'h00, 1'b0);
        live_word = rdata_i;
        acc(`NVM_OFS_PROG_DAC, 8'h00, 1'b1);
        settle();
        saw_done = done_i;
        acc(`NVM_OFS_ADDR_CTRL, {2'b00, a}, 1'b1);
        acc(`NVM_OFS_PUMP_BIAS, 8'h00, 1'b1);
    endtask
endmodule // nvmseq_fw_model
`default_nettype wire

//--- tb/nvmseq_tb_top.sv
// Self-checking bench for the NVM access block
`timescale 1ns/1ps
`default_nettype none
`include "nvmseq_params.svh"
module nvmseq_tb_top;
    logic core_clk_i;
    logic rstn_i;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, thr;
    logic sfr_wr, sfr_rd, prog, done, single, dbl, tout;
    logic [5:0] gen_ref;
    logic [7:0] r;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    localparam logic [2:0] CHK [16] = '{3'h7, 3'h0, 3'h4, 3'h3, 3'h2, 3'h5, 3'h1, 3'h6,
                                       3'h1, 3'h6, 3'h2, 3'h5, 3'h4, 3'h3, 3'h7, 3'h0};
    nvmseq_top dut_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr),
        .sfr_wdata_i(sfr_wdata), .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_rdata_o(sfr_rdata),
        .programming_o(prog), .prog_done_o(done), .ecc_single_o(single), .ecc_double_o(dbl),
        .test_out_o(tout), .generator_reference_voltage_o(gen_ref),
        .radio_detector_threshold_o(thr));
    nvmseq_fw_model fw_u (.core_clk_i(core_clk_i), .sfr_addr_o(sfr_addr),
        .sfr_wdata_o(sfr_wdata), .sfr_wr_o(sfr_wr), .sfr_rd_o(sfr_rd), .prog_i(prog),
        .done_i(done), .rdata_i(sfr_rdata), .dac_i(gen_ref));
    initial
    begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    task automatic give_verdict();
        if (n_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_word(input logic [5:0] a);
        fw_u.acc(`NVM_OFS_ADDR_CTRL, {2'b00, a}, 1'b1);
        fw_u.acc(`NVM_OFS_WORD_DATA, 8'h00, 1'b0);
        r = sfr_rdata;
    endtask
    // All user addresses, clean words
    task automatic t_clean();
        for (int i = 0; i < 14; i++)
        begin
            fw_u.program_word(6'(i + 2), 4'(i), 7'h00, 1'b1);
            check("pulse", {7'h00, fw_u.saw_pulse}, 8'h01);
            check("gen_ref", {2'b00, gen_ref}, 8'h00);
            check("threshold", thr, {1'b0, CHK[i], 4'(i)});
            check("live word", fw_u.live_word, {1'b1, CHK[i], 4'(i)});
            check("live dac", {2'b00, fw_u.live_dac}, 8'h17);
            check("done set", {7'h00, fw_u.saw_done}, 8'h01);
            check("done clear", {7'h00, done}, 8'h00);
        end
        for (int i = 0; i < 14; i++)
        begin
            rd_word(6'(i + 2));
            check("word", r, {1'b0, CHK[i], 4'(i)});
            check("single", {7'h00, single}, 8'h00);
            check("testout", {7'h00, tout}, 8'h00);
        end
    endtask
    // One flipped bit in each position
    task automatic t_single();
        logic [6:0] f;
        for (int b = 0; b < 7; b++)
        begin
            f = 7'h01 << b;
            fw_u.program_word(6'(b + 2), 4'(b + 9), f, 1'b1);
            rd_word(6'(b + 2));
            check("corrected", r, {1'b0, CHK[b + 9] ^ f[6:4], 4'(b + 9)});
            check("single", {7'h00, single}, 8'h01);
            check("double", {7'h00, dbl}, 8'h00);
        end
    endtask
    // Pump left off leaves the word alone
    task automatic t_refused();
        fw_u.program_word(6'h0F, 4'h3, 7'h00, 1'b0);
        check("no pulse", {7'h00, fw_u.saw_pulse}, 8'h00);
        check("no done", {7'h00, fw_u.saw_done}, 8'h00);
        check("live unarmed", fw_u.live_word, {1'b0, CHK[13], 4'hD});
        rd_word(6'h0F);
        check("unarmed", r, {1'b0, CHK[13], 4'hD});
        fw_u.program_word(6'h10, 4'h5, 7'h00, 1'b1);
        rd_word(6'h10);
        check("reserved", r, {1'b0, CHK[1], 4'h1});
        fw_u.acc(8'h90, 8'h00, 1'b0);
        check("unmapped", sfr_rdata, 8'h00);
    endtask
    initial
    begin
        rstn_i = 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
        rstn_i = 1'b1;
        t_clean();
        t_single();
        t_refused();
        give_verdict();
    end
endmodule // nvmseq_tb_top
`default_nettype wire
